/* File: src/dma_addr_pkg.sv */
// Package for the DMA channel address register bank.
// Assumes APB with 32-bit data and one aligned word per register.
package dma_addr_pkg;
    localparam int ADDR_W = 24;
    localparam int REG_W = 16;
    localparam int HIGH_W = 8;
    localparam int PADDR_W = 12;
    // Register byte offsets (chosen: none printed)
    localparam logic [11:0] OFF_START_HIGH = 12'h000;
    localparam logic [11:0] OFF_START_LOW = 12'h004;
    localparam logic [11:0] OFF_LAST_HIGH = 12'h008;
    localparam logic [11:0] OFF_LAST_LOW = 12'h00C;
    localparam logic [11:0] OFF_XFER_CTRL = 12'h010;
    localparam logic [11:0] OFF_XFER_STAT = 12'h014;
    localparam logic [23:0] ADDR_RESET = 24'h00_0000;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
    // Control and status register fields
    localparam int CTRL_DIR_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_LAST = 2'b11
    } xfer_state_e;
endpackage : dma_addr_pkg

/* File: src/dma_ram_addr_gen.sv */
// Address walker: steps a 24-bit RAM address through a transfer.
// Assumes the engine raises step once per RAM access it performs.
`timescale 1ns/1ps
module dma_ram_addr_gen #(
    parameter int ADDR_W = 24
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic load,
    input wire logic [ADDR_W-1:0] base,
    input wire logic step,
    // Current address
    output logic [ADDR_W-1:0] addr
);
    logic [ADDR_W-1:0] addr_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_r <= '0;
        end else if (load) begin
            addr_r <= base;
        end else if (step) begin
            addr_r <= addr_r + ADDR_W'(1);
        end
    end
    assign addr = addr_r;
endmodule : dma_ram_addr_gen

/* File: src/dma_channel_address_regs.sv */
// APB register bank for one DMA channel's start address and the
// most recent RAM address touched by the DMA engine.
// Assumes an APB master on pclk; engine access strobes synchronous.
// Contract
// (RULE1) Bits 15..8 of each upper address register read zero and ignore writes.
// (RULE2) Upper start register bits 7..0 hold start address bits 23..16, RW, reset zero.
// (RULE3) Lower start register holds start address bits 15..0, RW, reset zero.
// (RULE4) The 24-bit start address is the source or destination of the transfer.
// (RULE5) Upper recent register bits 7..0 report recent address bits 23..16, RO.
// (RULE6) Lower recent register reports recent address bits 15..0, RO, reset zero.
// (RULE7) Each engine RAM access updates the recent pair; software writes do nothing.
`timescale 1ns/1ps
module dma_channel_address_regs #(
    parameter int ADDR_W = 24,
    parameter int LEN_W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Engine side
    input wire logic xfer_start,
    input wire logic ram_access,
    input wire logic [LEN_W-1:0] xfer_len,
    output logic [ADDR_W-1:0] ram_addr,
    output logic ram_addr_is_src,
    output logic xfer_busy
);
    logic [ADDR_W-1:0] start_addr_r;
    logic [ADDR_W-1:0] last_addr_r;
    logic dir_src_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [ADDR_W-1:0] ram_addr_r;
    logic busy_r;
    logic [LEN_W-1:0] left_r;
    logic [ADDR_W-1:0] walk_addr;
    dma_addr_pkg::xfer_state_e state_r;
    logic wr_en;
    logic rd_en;
    logic acc_en;
    logic pready_r;

    // Decode shared by the error flag and its check
    function automatic logic hit(input logic [11:0] a);
        hit = (a == dma_addr_pkg::OFF_START_HIGH) || (a == dma_addr_pkg::OFF_START_LOW)
            || (a == dma_addr_pkg::OFF_LAST_HIGH) || (a == dma_addr_pkg::OFF_LAST_LOW)
            || (a == dma_addr_pkg::OFF_XFER_CTRL) || (a == dma_addr_pkg::OFF_XFER_STAT);
    endfunction : hit

    function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
                                      input logic en);
        lane = en ? nw : old;
    endfunction : lane

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign acc_en = psel && penable;

    // RULE2 RULE3 RULE1 start address writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_addr_r <= dma_addr_pkg::ADDR_RESET;
            dir_src_r <= 1'b0;
        end else if (wr_en) begin
            unique case (paddr)
                // RULE1 RULE2 upper byte only
                dma_addr_pkg::OFF_START_HIGH: begin
                    start_addr_r[23:16] <= lane(start_addr_r[23:16], pwdata[7:0], pstrb[0]);
                end
                // RULE3 both low lanes
                dma_addr_pkg::OFF_START_LOW: begin
                    start_addr_r[15:8] <= lane(start_addr_r[15:8], pwdata[15:8], pstrb[1]);
                    start_addr_r[7:0] <= lane(start_addr_r[7:0], pwdata[7:0], pstrb[0]);
                end
                // RULE4 source or destination
                dma_addr_pkg::OFF_XFER_CTRL: begin
                    if (pstrb[0]) begin
                        dir_src_r <= pwdata[dma_addr_pkg::CTRL_DIR_BIT];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // RULE4 transfer sequencing
    // A zero length start is dropped: no access, no busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= dma_addr_pkg::ST_IDLE;
            left_r <= '0;
        end else begin
            unique case (state_r)
                dma_addr_pkg::ST_IDLE: begin
                    if (xfer_start && xfer_len != '0) begin
                        left_r <= xfer_len;
                        state_r <= (xfer_len == LEN_W'(1)) ? dma_addr_pkg::ST_LAST
                                                           : dma_addr_pkg::ST_RUN;
                    end
                end
                dma_addr_pkg::ST_RUN: begin
                    if (ram_access) begin
                        left_r <= left_r - LEN_W'(1);
                        if (left_r == LEN_W'(2)) begin
                            state_r <= dma_addr_pkg::ST_LAST;
                        end
                    end
                end
                dma_addr_pkg::ST_LAST: begin
                    if (ram_access) begin
                        left_r <= '0;
                        state_r <= dma_addr_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= dma_addr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // RULE4 start address seeds the walk
    dma_ram_addr_gen #(
        .ADDR_W(ADDR_W)
    ) u_walk (
        .pclk(pclk),
        .presetn(presetn),
        .load(state_r == dma_addr_pkg::ST_IDLE),
        .base(start_addr_r),
        .step(ram_access && state_r != dma_addr_pkg::ST_IDLE),
        .addr(walk_addr)
    );

    // Outputs registered; address presented is the start while idle, else the walk's
    // One edge behind the walk, traded for a glitch-free address pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_addr_r <= dma_addr_pkg::ADDR_RESET;
            busy_r <= 1'b0;
        end else begin
            ram_addr_r <= (state_r == dma_addr_pkg::ST_IDLE) ? start_addr_r : walk_addr;
            busy_r <= (state_r != dma_addr_pkg::ST_IDLE);
        end
    end

    // RULE7 RULE5 RULE6 recent address capture
    // Strobes while idle are not engine accesses and are ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_addr_r <= dma_addr_pkg::ADDR_RESET;
        end else if (ram_access && state_r != dma_addr_pkg::ST_IDLE) begin
            last_addr_r <= walk_addr;
        end
    end

    // RULE1 RULE5 RULE6 read mux, upper bits zero
    // Launched at setup so the word stands through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= dma_addr_pkg::DATA_ZERO;
        end else if (rd_en) begin
            prdata_r <= dma_addr_pkg::DATA_ZERO;
            unique case (paddr)
                // RULE1 RULE2 top bits stay zero
                dma_addr_pkg::OFF_START_HIGH: begin
                    prdata_r[7:0] <= start_addr_r[23:16];
                end
                // RULE3 full low half
                dma_addr_pkg::OFF_START_LOW: begin
                    prdata_r[15:0] <= start_addr_r[15:0];
                end
                // RULE5 recent upper byte
                dma_addr_pkg::OFF_LAST_HIGH: begin
                    prdata_r[7:0] <= last_addr_r[23:16];
                end
                // RULE6 recent low half
                dma_addr_pkg::OFF_LAST_LOW: begin
                    prdata_r[15:0] <= last_addr_r[15:0];
                end
                dma_addr_pkg::OFF_XFER_CTRL: begin
                    prdata_r[dma_addr_pkg::CTRL_DIR_BIT] <= dir_src_r;
                end
                dma_addr_pkg::OFF_XFER_STAT: begin
                    prdata_r[dma_addr_pkg::STAT_BUSY_BIT] <= busy_r;
                end
                default: begin
                end
            endcase
        end
    end

    // Unmapped addresses answer with an error, zero data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_r <= 1'b0;
        end else begin
            pslverr_r <= psel && !penable && !hit(paddr);
        end
    end

    // Ready low through reset, then every access completes at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= 1'b1;
        end
    end

    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign pready = pready_r;
    assign ram_addr = ram_addr_r;
    assign ram_addr_is_src = dir_src_r;
    assign xfer_busy = busy_r;

    // Checks run out of reset only; reset values are left to the bench
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    upper_start_zero_a: assert property ( // RULE1
        rd_en && paddr == dma_addr_pkg::OFF_START_HIGH |=> prdata[31:8] == '0)
        else $error("upper start bits not zero");
    start_high_wr_a: assert property ( // RULE2
        wr_en && paddr == dma_addr_pkg::OFF_START_HIGH && pstrb[0]
        |=> start_addr_r[23:16] == $past(pwdata[7:0]))
        else $error("start high not written");
    start_low_wr_a: assert property ( // RULE3
        wr_en && paddr == dma_addr_pkg::OFF_START_LOW && pstrb[1:0] == 2'b11
        |=> start_addr_r[15:0] == $past(pwdata[15:0]))
        else $error("start low not written");
    walk_seed_a: assert property ( // RULE4
        state_r == dma_addr_pkg::ST_IDLE
        |=> ram_addr == $past(start_addr_r))
        else $error("ram address not seeded from start");
    recent_high_rd_a: assert property ( // RULE5
        rd_en && paddr == dma_addr_pkg::OFF_LAST_HIGH
        |=> prdata == {24'h00_0000, $past(last_addr_r[23:16])})
        else $error("recent high readback wrong");
    recent_low_rd_a: assert property ( // RULE6
        rd_en && paddr == dma_addr_pkg::OFF_LAST_LOW
        |=> prdata == {16'h0000, $past(last_addr_r[15:0])})
        else $error("recent low readback wrong");
    recent_update_a: assert property ( // RULE7
        ram_access && state_r != dma_addr_pkg::ST_IDLE |=> last_addr_r == $past(walk_addr))
        else $error("recent address not captured");
    recent_hold_a: assert property ( // RULE7
        !(ram_access && state_r != dma_addr_pkg::ST_IDLE) |=> $stable(last_addr_r))
        else $error("recent address changed without access");

    upper_ignore_a: assert property ( // RULE1
        wr_en && paddr == dma_addr_pkg::OFF_START_HIGH
        |=> start_addr_r[15:0] == $past(start_addr_r[15:0]))
        else $error("upper write disturbed low bits");
    high_keep_a: assert property ( // RULE2
        !(wr_en && paddr == dma_addr_pkg::OFF_START_HIGH && pstrb[0])
        |=> $stable(start_addr_r[23:16]))
        else $error("start high changed without write");
    start_high_rd_a: assert property ( // RULE2
        rd_en && paddr == dma_addr_pkg::OFF_START_HIGH
        |=> prdata == {24'h00_0000, $past(start_addr_r[23:16])})
        else $error("start high readback wrong");
    low_lane_a: assert property ( // RULE3
        wr_en && paddr == dma_addr_pkg::OFF_START_LOW && pstrb[1:0] == 2'b01
        |=> start_addr_r[15:8] == $past(start_addr_r[15:8]))
        else $error("unstrobed low lane written");
    start_low_rd_a: assert property ( // RULE3
        rd_en && paddr == dma_addr_pkg::OFF_START_LOW
        |=> prdata == {16'h0000, $past(start_addr_r[15:0])})
        else $error("start low readback wrong");
    dir_follow_a: assert property ( // RULE4
        wr_en && paddr == dma_addr_pkg::OFF_XFER_CTRL && pstrb[0]
        |=> ram_addr_is_src == $past(pwdata[dma_addr_pkg::CTRL_DIR_BIT]))
        else $error("direction not taken from control");
    walk_step_a: assert property ( // RULE4
        ram_access && state_r != dma_addr_pkg::ST_IDLE
        |=> walk_addr == $past(walk_addr) + ADDR_W'(1))
        else $error("walk address did not step");
    unmapped_err_a: assert property (
        acc_en && !hit(paddr) |-> pslverr)
        else $error("unmapped access without error");

    // Main scenarios
    start_write_c: cover property (wr_en && paddr == dma_addr_pkg::OFF_START_LOW);
    xfer_run_c: cover property (state_r == dma_addr_pkg::ST_RUN ##[1:20]
        state_r == dma_addr_pkg::ST_IDLE);
    recent_read_c: cover property (rd_en && paddr == dma_addr_pkg::OFF_LAST_LOW
        && last_addr_r != '0);
    single_xfer_c: cover property (state_r == dma_addr_pkg::ST_IDLE ##1
        state_r == dma_addr_pkg::ST_LAST);
    unmapped_c: cover property (pslverr && pready);
endmodule : dma_channel_address_regs

/* File: test/dma_channel_address_regs_test.sv */
// Self-checking bench for the DMA channel address register bank.
// Assumes an APB slave on pclk answering within 16 cycles; engine strobe synchronous.
`timescale 1ns/1ps
module dma_channel_address_regs_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic xfer_start = 1'b0;
    logic ram_access = 1'b0;
    logic [15:0] xfer_len = 16'h0000;
    logic [23:0] ram_addr;
    logic ram_addr_is_src;
    logic xfer_busy;
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int total_checks = 0;
    int n;

    always #2.5 pclk = ~pclk;

    dma_channel_address_regs dut_u (
        .pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xfer_start(xfer_start), .ram_access(ram_access),
        .xfer_len(xfer_len), .ram_addr(ram_addr), .ram_addr_is_src(ram_addr_is_src),
        .xfer_busy(xfer_busy)
    );

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : chk

    // Idle edge first, so a release never meets a new setup in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            n_fail++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        chk(rd, exp);
    endtask : rd_chk

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(dma_addr_pkg::OFF_START_HIGH, dma_addr_pkg::DATA_ZERO);
        chk({31'h0, err}, 32'h0000_0000);
        rd_chk(dma_addr_pkg::OFF_START_LOW, dma_addr_pkg::DATA_ZERO);
        rd_chk(dma_addr_pkg::OFF_LAST_HIGH, dma_addr_pkg::DATA_ZERO);
        rd_chk(dma_addr_pkg::OFF_LAST_LOW, dma_addr_pkg::DATA_ZERO);
        apb(1'b1, dma_addr_pkg::OFF_START_HIGH, 32'hFFFF_FFFF, 4'hf);
        rd_chk(dma_addr_pkg::OFF_START_HIGH, 32'h0000_00FF);
        apb(1'b1, dma_addr_pkg::OFF_START_HIGH, 32'hFFFF_FF12, 4'hf);
        rd_chk(dma_addr_pkg::OFF_START_HIGH, 32'h0000_0012);
        // Lane strobes: each half of the low word written alone
        apb(1'b1, dma_addr_pkg::OFF_START_LOW, 32'h0000_ABFE, 4'h1);
        rd_chk(dma_addr_pkg::OFF_START_LOW, 32'h0000_00FE);
        apb(1'b1, dma_addr_pkg::OFF_START_LOW, 32'h0000_FF11, 4'h2);
        rd_chk(dma_addr_pkg::OFF_START_LOW, 32'h0000_FFFE);
        apb(1'b1, dma_addr_pkg::OFF_START_LOW, 32'hABCD_FFFE, 4'hf);
        rd_chk(dma_addr_pkg::OFF_START_LOW, 32'h0000_FFFE);
        apb(1'b1, dma_addr_pkg::OFF_LAST_HIGH, 32'hFFFF_FFFF, 4'hf);
        apb(1'b1, dma_addr_pkg::OFF_LAST_LOW, 32'hFFFF_FFFF, 4'hf);
        rd_chk(dma_addr_pkg::OFF_LAST_HIGH, dma_addr_pkg::DATA_ZERO);
        rd_chk(dma_addr_pkg::OFF_LAST_LOW, dma_addr_pkg::DATA_ZERO);
        apb(1'b0, 12'h020, 32'h0000_0000, 4'h0);
        chk({31'h0, err}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        apb(1'b1, dma_addr_pkg::OFF_XFER_CTRL, 32'h0000_0001, 4'hf);
        @(negedge pclk);
        chk({31'h0, ram_addr_is_src}, 32'h0000_0001);
        chk({8'h00, ram_addr}, 32'h0012_FFFE);
        // Three accesses walk across the high byte boundary
        @(posedge pclk);
        xfer_start <= 1'b1;
        xfer_len <= 16'h0003;
        @(posedge pclk);
        xfer_start <= 1'b0;
        // Busy is registered from the state, one edge after it
        @(posedge pclk);
        @(negedge pclk);
        chk({31'h0, xfer_busy}, 32'h0000_0001);
        for (int k = 0; k < 3; k++) begin
            // The address pin follows the walk one edge later
            @(posedge pclk);
            @(negedge pclk);
            chk({8'h00, ram_addr}, 32'h0012_FFFE + k);
            @(posedge pclk);
            ram_access <= 1'b1;
            @(posedge pclk);
            ram_access <= 1'b0;
            if (k == 0) begin
                rd_chk(dma_addr_pkg::OFF_LAST_LOW, 32'h0000_FFFE);
                rd_chk(dma_addr_pkg::OFF_XFER_STAT, 32'h0000_0001);
            end
        end
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (xfer_busy !== 1'b0 && n < 10);
        chk({31'h0, xfer_busy}, 32'h0000_0000);
        rd_chk(dma_addr_pkg::OFF_LAST_HIGH, 32'h0000_0013);
        rd_chk(dma_addr_pkg::OFF_LAST_LOW, 32'h0000_0000);
        apb(1'b1, dma_addr_pkg::OFF_XFER_CTRL, 32'h0000_0000, 4'hf);
        @(negedge pclk);
        chk({31'h0, ram_addr_is_src}, 32'h0000_0000);
        chk({8'h00, ram_addr}, 32'h0012_FFFE);
        // One access: straight to the last step, recent address is the start
        @(posedge pclk);
        xfer_start <= 1'b1;
        xfer_len <= 16'h0001;
        @(posedge pclk);
        xfer_start <= 1'b0;
        ram_access <= 1'b1;
        @(posedge pclk);
        ram_access <= 1'b0;
        rd_chk(dma_addr_pkg::OFF_LAST_LOW, 32'h0000_FFFE);
        rd_chk(dma_addr_pkg::OFF_LAST_HIGH, 32'h0000_0012);
        // Zero length starts nothing; idle strobes leave the recent pair
        apb(1'b1, dma_addr_pkg::OFF_START_LOW, 32'h0000_1234, 4'h3);
        @(posedge pclk);
        xfer_start <= 1'b1;
        xfer_len <= 16'h0000;
        @(posedge pclk);
        xfer_start <= 1'b0;
        ram_access <= 1'b1;
        @(posedge pclk);
        ram_access <= 1'b0;
        rd_chk(dma_addr_pkg::OFF_XFER_STAT, 32'h0000_0000);
        rd_chk(dma_addr_pkg::OFF_LAST_LOW, 32'h0000_FFFE);
        @(negedge pclk);
        chk({8'h00, ram_addr}, 32'h0012_1234);
        end_sim();
    end
endmodule : dma_channel_address_regs_test
